// ==== verilog/lat_pkg.sv ====
// Constants and types of the light sensor conversion and threshold block
// Summary of operation
// [R1] Low threshold bytes at 04/05, reset 00
// [R2] High threshold bytes at 06/07, reset ff
// [R3] Integration lasts exactly 2^n oscillator cycles
// [R4] Resolution from command II bits 3:2
// [R5] Result to data bytes 02/03, scale 2^n
// [R6] Host converts data to lux itself
// [R7] Scheme one subtracts ambient, signed, half resolution
// [R8] Host may difference proximity and IR results
// [R9] Host picks flicker-cancelling integration time
// [R10] Codes 00,01,10,11 give 16,12,8,4 bits
// [R11] Flag after m consecutive out-of-window results
// [R12] Flag stays until command I write completes
// [R13] Mode change zeroes persist counter
// [R14] Unsigned 16-bit compare against assembled thresholds
package lat_pkg;
   localparam logic [2:0] LAT_ADDR_CMD1 = 3'h0;
   localparam logic [2:0] LAT_ADDR_CMD2 = 3'h1;
   localparam logic [2:0] LAT_ADDR_DATA_LSB = 3'h2;
   localparam logic [2:0] LAT_ADDR_DATA_MSB = 3'h3;
   localparam logic [2:0] LAT_ADDR_LOW_LSB = 3'h4;
   localparam logic [2:0] LAT_ADDR_LOW_MSB = 3'h5;
   localparam logic [2:0] LAT_ADDR_HIGH_LSB = 3'h6;
   localparam logic [2:0] LAT_ADDR_HIGH_MSB = 3'h7;
   localparam logic [7:0] LAT_RST_CMD = 8'h00;
   localparam logic [7:0] LAT_RST_DATA = 8'h00;
   localparam logic [7:0] LAT_RST_LOW = 8'h00;
   localparam logic [7:0] LAT_RST_HIGH = 8'hff;
   localparam int LAT_MODE_POS = 5;
   localparam int LAT_FLAG_POS = 2;
   localparam int LAT_PERSIST_POS = 0;
   localparam int LAT_SCHEME_POS = 7;
   localparam int LAT_RES_POS = 2;
   localparam logic [7:0] LAT_CMD1_WMASK = 8'he3;
   localparam logic [2:0] LAT_MODE_OFF = 3'h0;
   localparam logic [16:0] LAT_CNT_MAX = 17'h0ffff;
   localparam logic [16:0] LAT_CYC_RES16 = 17'h10000;
   localparam logic [16:0] LAT_CYC_RES12 = 17'h01000;
   localparam logic [16:0] LAT_CYC_RES8 = 17'h00100;
   localparam logic [16:0] LAT_CYC_RES4 = 17'h00010;
   localparam logic [4:0] LAT_PERSIST_1 = 5'h01;
   localparam logic [4:0] LAT_PERSIST_4 = 5'h04;
   localparam logic [4:0] LAT_PERSIST_8 = 5'h08;
   localparam logic [4:0] LAT_PERSIST_16 = 5'h10;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } lat_bus_req_t;

   typedef enum {LAT_IDLE, LAT_INTEG} lat_state_t;
endpackage

// ==== verilog/lat_core.sv ====
// Conversion timing, result registers and threshold interrupt
`timescale 1ns/1ps
`default_nettype none
module lat_core (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire lat_pkg::lat_bus_req_t bus_req,
   output logic [7:0] reg_rdata,
   input wire logic osc_clk_pin,
   input wire logic charge_pulse_pin,
   input wire logic led_phase_pin,
   output logic conv_done,
   output logic int_n
);
   import lat_pkg::*;

   logic [7:0] cmd1_q, cmd2_q, data_lsb_q, data_msb_q;
   logic [7:0] low_lsb_q, low_msb_q, high_lsb_q, high_msb_q;
   logic [2:0] s1_q, s2_q, s3_q;
   lat_state_t state_q;
   logic [16:0] osc_cnt_q, target;
   logic signed [16:0] acc_q;
   logic [15:0] result, low_thr, high_thr;
   logic [4:0] persist_q, persist_m;
   logic [2:0] mode_q;
   logic once_done_q, flag_q, end_conv, outside, run;
   logic osc_edge, pulse_edge, led_on, cmd1_wr, mode_change;
   logic res_change;

   // Pins pass two flops; third stage serves edge detect only
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_q <= 3'h0;
         s2_q <= 3'h0;
         s3_q <= 3'h0;
      end else begin
         s1_q <= {led_phase_pin, charge_pulse_pin, osc_clk_pin};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   assign osc_edge = s2_q[0] & ~s3_q[0];
   assign pulse_edge = s2_q[1] & ~s3_q[1];
   assign led_on = s2_q[2];

   assign cmd1_wr = bus_req.wr && (bus_req.addr == LAT_ADDR_CMD1);
   assign mode_change = cmd1_wr &&
      (bus_req.wdata[LAT_MODE_POS +: 3] != cmd1_q[LAT_MODE_POS +: 3]);
   // A new resolution restarts the count, so no result mixes two lengths
   assign res_change = bus_req.wr && (bus_req.addr == LAT_ADDR_CMD2) &&
      (bus_req.wdata[LAT_RES_POS +: 2] != cmd2_q[LAT_RES_POS +: 2]);

   // Code 00 is the longest integration
   always_comb begin
      unique case (cmd2_q[LAT_RES_POS +: 2]) // [R4]
         2'b00: target = LAT_CYC_RES16; // [R10]
         2'b01: target = LAT_CYC_RES12; // [R10]
         2'b10: target = LAT_CYC_RES8; // [R10]
         2'b11: target = LAT_CYC_RES4; // [R10]
      endcase
   end

   // Persist code picks how many results in a row must miss the window
   always_comb begin
      unique case (cmd1_q[LAT_PERSIST_POS +: 2])
         2'b00: persist_m = LAT_PERSIST_1; // [R11]
         2'b01: persist_m = LAT_PERSIST_4; // [R11]
         2'b10: persist_m = LAT_PERSIST_8; // [R11]
         2'b11: persist_m = LAT_PERSIST_16; // [R11]
      endcase
   end

   assign mode_q = cmd1_q[LAT_MODE_POS +: 3];
   // Once modes stop after one result; continuous modes have bit 7 set
   assign run = (mode_q != LAT_MODE_OFF) && (mode_q[2] || !once_done_q);
   // An aborted integration never reports a result
   assign end_conv = (state_q == LAT_INTEG) && osc_edge &&
      !mode_change && !res_change &&
      (osc_cnt_q == target - 17'h00001); // [R3]

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= LAT_IDLE;
         osc_cnt_q <= 17'h0;
      end else if (mode_change || res_change ||
                   !run) begin
         state_q <= LAT_IDLE;
         osc_cnt_q <= 17'h0;
      end else begin
         unique case (state_q)
            LAT_IDLE: begin
               if (osc_edge) begin
                  state_q <= LAT_INTEG;
                  osc_cnt_q <= 17'h0;
               end
            end
            LAT_INTEG: begin
               if (end_conv) begin
                  osc_cnt_q <= 17'h0; // [R3]
               end else if (osc_edge) begin
                  osc_cnt_q <= osc_cnt_q + 17'h00001; // [R3]
               end
            end
         endcase
      end
   end

   // Charge packets count up; under scheme one the LED-off phase
   // counts down, which removes the ambient share on chip
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         acc_q <= 17'sh0;
      end else if (state_q != LAT_INTEG || end_conv) begin
         acc_q <= 17'sh0;
      end else if (pulse_edge) begin
         if (cmd2_q[LAT_SCHEME_POS] && !led_on) begin
            acc_q <= acc_q - 17'sh00001; // [R7]
         end else if (acc_q != $signed(LAT_CNT_MAX)) begin
            acc_q <= acc_q + 17'sh00001;
         end
      end
   end

   // Scheme one keeps the sign and drops one bit of resolution
   assign result = cmd2_q[LAT_SCHEME_POS] ?
      acc_q[16:1] : acc_q[15:0]; // [R7]

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         data_lsb_q <= LAT_RST_DATA;
         data_msb_q <= LAT_RST_DATA;
         conv_done <= 1'b0;
         once_done_q <= 1'b0;
      end else begin
         // Pulse rises on the same edge as the data load so a reader sees fresh bytes
         conv_done <= end_conv;
         if (end_conv) begin
            data_lsb_q <= result[7:0]; // [R5]
            data_msb_q <= result[15:8]; // [R5]
         end
         if (mode_change) begin
            once_done_q <= 1'b0;
         end else if (end_conv) begin
            once_done_q <= 1'b1;
         end
      end
   end

   assign low_thr = {low_msb_q, low_lsb_q}; // [R14]
   assign high_thr = {high_msb_q, high_lsb_q}; // [R14]
   assign outside = (result < low_thr) || (result > high_thr); // [R14]

   // Count saturates at m, so a long run cannot wrap back below it
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         persist_q <= 5'h0;
      end else if (mode_change) begin
         persist_q <= 5'h0; // [R13]
      end else if (end_conv) begin
         if (!outside) begin
            persist_q <= 5'h0; // [R11]
         end else if (persist_q < persist_m) begin
            persist_q <= persist_q + 5'h01; // [R11]
         end
      end
   end

   // A new trigger in the clearing cycle wins over the clear
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         flag_q <= 1'b0;
      end else if (end_conv && outside && !mode_change &&
                   persist_q + 5'h01 >= persist_m) begin
         flag_q <= 1'b1; // [R11]
      end else if (cmd1_wr) begin
         flag_q <= 1'b0; // [R12]
      end
   end
   assign int_n = ~flag_q; // [R11]

   // Data bytes are read only; a write to them is dropped
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmd1_q <= LAT_RST_CMD;
         cmd2_q <= LAT_RST_CMD;
         low_lsb_q <= LAT_RST_LOW; // [R1]
         low_msb_q <= LAT_RST_LOW; // [R1]
         high_lsb_q <= LAT_RST_HIGH; // [R2]
         high_msb_q <= LAT_RST_HIGH; // [R2]
      end else if (bus_req.wr) begin
         unique case (bus_req.addr)
            LAT_ADDR_CMD1: cmd1_q <= bus_req.wdata & LAT_CMD1_WMASK;
            LAT_ADDR_CMD2: cmd2_q <= bus_req.wdata;
            LAT_ADDR_LOW_LSB: low_lsb_q <= bus_req.wdata; // [R1]
            LAT_ADDR_LOW_MSB: low_msb_q <= bus_req.wdata; // [R1]
            LAT_ADDR_HIGH_LSB: high_lsb_q <= bus_req.wdata; // [R2]
            LAT_ADDR_HIGH_MSB: high_msb_q <= bus_req.wdata; // [R2]
            default: ;
         endcase
      end
   end

   // Bit 2 of command I shows the live flag, never a stored bit
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (bus_req.rd) begin
         unique case (bus_req.addr)
            LAT_ADDR_CMD1: reg_rdata <= cmd1_q | {5'h00, flag_q, 2'h0};
            LAT_ADDR_CMD2: reg_rdata <= cmd2_q;
            LAT_ADDR_DATA_LSB: reg_rdata <= data_lsb_q; // [R5]
            LAT_ADDR_DATA_MSB: reg_rdata <= data_msb_q; // [R5]
            LAT_ADDR_LOW_LSB: reg_rdata <= low_lsb_q;
            LAT_ADDR_LOW_MSB: reg_rdata <= low_msb_q;
            LAT_ADDR_HIGH_LSB: reg_rdata <= high_lsb_q;
            LAT_ADDR_HIGH_MSB: reg_rdata <= high_msb_q;
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== tb/lat_front.sv ====
// Oscillator and charge pulse model of the analog front end
`timescale 1ns/1ps
`default_nettype none
module lat_front (
   input wire logic sys_clk,
   input wire logic pulse_en,
   output logic osc_out,
   output logic charge_out
);
   logic [1:0] ph_q = 2'h0;
   // Fixed four-clock period keeps integration lengths exact
   always @(posedge sys_clk) begin
      ph_q <= ph_q + 2'h1;
      osc_out <= ph_q[1];
      charge_out <= pulse_en & ~ph_q[1];
   end
endmodule
`default_nettype wire

// ==== tb/lat_core_sva.sv ====
// Assertion checker for the conversion and threshold block
`timescale 1ns/1ps
`default_nettype none
module lat_core_sva (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire lat_pkg::lat_bus_req_t bus_req,
   input wire logic [7:0] reg_rdata,
   input wire logic osc_clk_pin,
   input wire logic charge_pulse_pin,
   input wire logic led_phase_pin,
   input wire logic conv_done,
   input wire logic int_n
);
   import lat_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   logic clr_w;
   assign clr_w = bus_req.wr && bus_req.addr == LAT_ADDR_CMD1;
   // A set in the write cycle wins, so only a quiet cycle must clear
   sequence s_clr;
      clr_w ##1 !conv_done;
   endsequence
   rst_idle_a: assert property (disable iff (1'b0)
      sys_rst |-> int_n && !conv_done) else $error("outputs busy in reset");
   done_pulse_a: assert property (conv_done |=> !conv_done [*8])
      else $error("conversions too close");
   int_set_a: assert property ($fell(int_n) |-> conv_done)
      else $error("interrupt set off a conversion end");
   int_hold_a: assert property (!int_n && !clr_w |=> !int_n)
      else $error("interrupt dropped without clear");
   int_clear_a: assert property (s_clr |-> int_n)
      else $error("interrupt not cleared");
   int_rise_a: assert property ($rose(int_n) |-> $past(clr_w))
      else $error("interrupt rose without write");
   rd_hold_a: assert property (!bus_req.rd |=> $stable(reg_rdata))
      else $error("read data moved");
   flag_read_a: assert property (bus_req.rd &&
      bus_req.addr == LAT_ADDR_CMD1 |=> reg_rdata[2] != $past(int_n))
      else $error("flag read failed");
endmodule
bind lat_core lat_core_sva u_sva (.sys_clk, .sys_rst, .bus_req, .reg_rdata,
   .osc_clk_pin, .charge_pulse_pin, .led_phase_pin, .conv_done, .int_n);
`default_nettype wire

// ==== tb/test_light_adc_threshold_interrupt.sv ====
// Self-checking bench for the conversion and threshold block
`timescale 1ns/1ps
`default_nettype none
module test_light_adc_threshold_interrupt;
   import lat_pkg::*;
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic [7:0] exp;
   } lat_row_t;
   logic sys_clk, sys_rst, pulse_en, osc, chg, conv_done, int_n, led;
   logic [7:0] reg_rdata;
   lat_bus_req_t bus_req;
   int num_errors = 0, n_checks = 0, cyc = 0, t0, i;
   lat_row_t rows [7] = '{'{3'h4, 8'ha5, 8'ha5}, '{3'h5, 8'h3c, 8'h3c},
      '{3'h6, 8'h5a, 8'h5a}, '{3'h7, 8'hc3, 8'hc3}, '{3'h2, 8'h77, 8'h00},
      '{3'h3, 8'h88, 8'h00}, '{3'h1, 8'h0c, 8'h0c}};
   lat_core uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(bus_req),
      .reg_rdata(reg_rdata), .osc_clk_pin(osc), .charge_pulse_pin(chg),
      .led_phase_pin(led), .conv_done(conv_done), .int_n(int_n));
   lat_front u_front (.sys_clk(sys_clk), .pulse_en(pulse_en), .osc_out(osc),
      .charge_out(chg));
   initial begin
      sys_clk = 0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         num_errors++;
         give_verdict;
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         num_errors++;
      end
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      bus_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge sys_clk);
      bus_req = '0;
   endtask
   task rd(input logic [2:0] a, input logic [7:0] e);
      @(negedge sys_clk);
      bus_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge sys_clk);
      bus_req = '0;
      chk(reg_rdata, e);
   endtask
   task wdone;
      @(negedge sys_clk);
      while (conv_done !== 1'b1) @(negedge sys_clk);
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      sys_rst = 1;
      bus_req = '0;
      pulse_en = 0;
      led = 0;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk) sys_rst = 0;
      for (i = 0; i < 8; i++) rd(3'(i), i >= 6 ? 8'hff : 8'h00);
      $display("reset values done");
      for (i = 0; i < 7; i++) begin
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, rows[i].exp);
      end
      $display("register rows done");
      wr(LAT_ADDR_CMD1, 8'ha0);
      // Full 16-bit count would outlast the run, so three codes are timed
      for (i = 3; i >= 1; i--) begin
         wr(LAT_ADDR_CMD2, 8'(i << LAT_RES_POS));
         wdone;
         wdone;
         t0 = cyc;
         wdone;
         chk(cyc - t0, 1 << (18 - 4 * i));
      end
      $display("resolution timing done");
      wr(LAT_ADDR_CMD2, 8'h0c);
      wr(LAT_ADDR_CMD1, 8'hc1);
      for (i = 1; i <= 4; i++) begin
         wdone;
         chk(int_n, i < 4);
      end
      rd(LAT_ADDR_CMD1, 8'hc5);
      rd(LAT_ADDR_DATA_LSB, 8'h00);
      $display("persist done");
      wr(LAT_ADDR_LOW_LSB, 8'h00);
      wr(LAT_ADDR_LOW_MSB, 8'h00);
      wdone;
      wr(LAT_ADDR_CMD1, 8'hc1);
      chk(int_n, 1'b1);
      repeat (5) begin
         wdone;
         chk(int_n, 1'b1);
      end
      pulse_en = 1;
      wr(LAT_ADDR_HIGH_LSB, 8'h00);
      wr(LAT_ADDR_HIGH_MSB, 8'h00);
      repeat (5) wdone;
      chk(int_n, 1'b0);
      $display("window done");
      // Scheme one: LED-off pulses count down, result is half the count
      wr(LAT_ADDR_CMD2, 8'h8c);
      repeat (2) wdone;
      rd(LAT_ADDR_DATA_LSB, 8'hf8);
      rd(LAT_ADDR_DATA_MSB, 8'hff);
      led = 1;
      repeat (2) wdone;
      rd(LAT_ADDR_DATA_LSB, 8'h08);
      rd(LAT_ADDR_DATA_MSB, 8'h00);
      $display("scheme done");
      give_verdict;
   end
endmodule
`default_nettype wire
